// ### pkg/rpw_pkg.sv
package rpw_pkg;
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_NS = 4; // system clock period
  localparam int SCAN_NS = 1000; // program scan period
  localparam int SCAN_CYC = (SCAN_NS + CLK_NS - 1) / CLK_NS; // cycles per scan
  localparam int TICK_US = 10000; // timebase tick period
  localparam int TICK_SCANS = (TICK_US * 1000) / SCAN_NS; // scans per tick
  // ************************************************
  // widths and values
  // ************************************************
  localparam int SCAN_W = 8; // scan divider width
  localparam int TICK_W = 24; // tick divider width
  localparam int DUR_W = 16; // duration in ticks
  localparam int MIN_W = 11; // minute of day
  localparam int DAY_W = 3; // weekday index
  localparam int DAYS = 7; // days in mask
  localparam int NUM_CAMS = 3; // cams per weekly switch
  localparam logic [MIN_W-1:0] MIN_LAST = 11'h59F; // 23:59
  localparam logic [MIN_W-1:0] MIN_UNUSED = 11'h7FF; // no action
  localparam logic [DAY_W-1:0] DAY_SUN = 3'h6; // mon is 0
  localparam logic OUT_RST = 1'b0; // output value after reset
  // ************************************************
  // types
  // ************************************************
  typedef enum logic {RPW_PM_LEVEL = 1'b0, RPW_PM_EDGE = 1'b1} rpw_pmode_t;
  typedef enum logic {RPW_PS_IDLE = 1'b0, RPW_PS_RUN = 1'b1} rpw_pstate_t;
  // one cam: bit 0 monday .. bit 6 sunday
  typedef struct packed {
    logic [DAYS-1:0] days;
    logic [MIN_W-1:0] on_min;
    logic [MIN_W-1:0] off_min;
  } rpw_cam_t;
  // current calendar time
  typedef struct packed {
    logic [DAY_W-1:0] day;
    logic [MIN_W-1:0] min;
  } rpw_clock_t;
  // latch or toggle controls
  typedef struct packed {
    logic set;
    logic clr;
    logic ret;
  } rpw_ctl_t;
  // pulse element controls
  typedef struct packed {
    logic trig;
    logic [DUR_W-1:0] dur;
  } rpw_pulse_in_t;
  // pulse element state
  typedef struct packed {
    rpw_pstate_t ph;
    logic trig_prev;
    logic [DUR_W-1:0] elapsed_time;
  } rpw_pulse_st_t;
  // top state
  typedef struct packed {
    logic [SCAN_W-1:0] scan_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic scan;
    logic tick;
    logic latch;
    logic tog;
    logic tog_prev;
    logic week;
    logic seen;
    rpw_clock_t prev;
  } rpw_top_st_t;
endpackage

// ### hw/rpw_pulse.sv
`timescale 1ns/1ns
module rpw_pulse #(
  parameter rpw_pkg::rpw_pmode_t MODE = rpw_pkg::RPW_PM_LEVEL
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // scan and timebase enables
  input wire logic scan_i,
  input wire logic tick_i,
  // trigger and duration
  input wire rpw_pkg::rpw_pulse_in_t pin_i,
  // pulse output
  output logic q_o
);
  import rpw_pkg::*;
  rpw_pulse_st_t st_q; // registered state
  rpw_pulse_st_t st_d; // next state
  logic rise; // trigger rising at this scan
  logic [DUR_W:0] nxt; // elapsed plus one, unclipped
  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_d = st_q;
    rise = pin_i.trig & ~st_q.trig_prev;
    nxt = {1'b0, st_q.elapsed_time} + {{DUR_W{1'b0}}, 1'b1};
    if (scan_i) begin
      st_d.trig_prev = pin_i.trig;
      if (rise) begin
        // start or retrigger
        st_d.ph = RPW_PS_RUN;
        st_d.elapsed_time = '0;
      end else if (st_q.ph == RPW_PS_RUN) begin
        if (MODE == RPW_PM_LEVEL && !pin_i.trig) begin
          // released early
          st_d.ph = RPW_PS_IDLE;
        end else if (tick_i) begin
          // count one timebase tick
          st_d.elapsed_time = nxt[DUR_W-1:0];
          if (nxt >= {1'b0, pin_i.dur}) begin
            st_d.ph = RPW_PS_IDLE;
          end
        end
      end
    end
  end
  // state register; elapsed time never survives reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q_o = (st_q.ph == RPW_PS_RUN);
  // ************************************************
  // checks
  // ************************************************
  AST_PULSE_RETRIG: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    scan_i && rise |=> q_o && st_q.elapsed_time == '0)
    else $error("pulse not restarted on rising trigger");
  AST_PULSE_RELEASE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    MODE == RPW_PM_LEVEL && scan_i && q_o && !pin_i.trig |=> !q_o)
    else $error("level pulse kept high after release");
  AST_PULSE_EXPIRE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    scan_i && tick_i && q_o && pin_i.trig && !rise && nxt >= {1'b0, pin_i.dur} |=> !q_o)
    else $error("pulse kept high past duration");
endmodule

// ### hw/rpw_top.sv
`timescale 1ns/1ns
module rpw_top #(
  // scans per timebase tick, shorten in simulation
  parameter int unsigned TICK_N = rpw_pkg::TICK_SCANS
) (
  // ************************************************
  // clock and reset
  // ************************************************
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // ************************************************
  // set/clear latch
  // ************************************************
  input wire rpw_pkg::rpw_ctl_t latch_i,
  // ************************************************
  // toggle relay, set field is the trigger
  // ************************************************
  input wire rpw_pkg::rpw_ctl_t tog_i,
  // ************************************************
  // level gated and edge started pulses
  // ************************************************
  input wire rpw_pkg::rpw_pulse_in_t wipe_i,
  input wire rpw_pkg::rpw_pulse_in_t edge_i,
  // ************************************************
  // weekly switch
  // ************************************************
  input wire rpw_pkg::rpw_clock_t now_i,
  input wire rpw_pkg::rpw_cam_t [rpw_pkg::NUM_CAMS-1:0] cam_i,
  // ************************************************
  // outputs
  // ************************************************
  output logic set_clear_latch_o,
  output logic toggle_o,
  output logic wipe_o,
  output logic edge_o,
  output logic week_o,
  output logic scan_o
);
  import rpw_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  rpw_top_st_t st_q; // registered state
  rpw_top_st_t st_d; // next state
  logic [NUM_CAMS-1:0] on_hit; // cam asks for on now
  logic [NUM_CAMS-1:0] off_hit; // cam asks for off now
  logic day_ok; // weekday index in range
  logic moved; // calendar time changed
  logic tog_rise; // toggle trigger rising
  logic week_act; // weekly switch acts this scan

  // ************************************************
  // cam decode, one copy per cam
  // ************************************************
  // weekday above sunday selects nothing
  assign day_ok = (now_i.day <= DAY_SUN);

  // calendar time differs from the last scan
  assign moved = (now_i != st_q.prev);

  // act only when the minute is newly reached
  assign week_act = st_q.scan && st_q.seen && moved;

  generate
    for (genvar c = 0; c < NUM_CAMS; c++) begin : g_cam
      // on time reached on a selected day
      assign on_hit[c] = day_ok
        && cam_i[c].days[now_i.day]
        && cam_i[c].on_min <= MIN_LAST
        && cam_i[c].on_min == now_i.min;
      // off time reached on a selected day
      assign off_hit[c] = day_ok
        && cam_i[c].days[now_i.day]
        && cam_i[c].off_min <= MIN_LAST
        && cam_i[c].off_min == now_i.min;
    end
  endgenerate

  // toggle trigger edge, sampled per scan
  assign tog_rise = tog_i.set && !st_q.tog_prev;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_d = st_q;
    // enables are one cycle pulses
    st_d.scan = 1'b0;
    st_d.tick = 1'b0;

    // scan divider
    if (st_q.scan_cnt == SCAN_W'(SCAN_CYC - 1)) begin
      st_d.scan_cnt = '0;
      st_d.scan = 1'b1;
      // timebase tick lands on a scan
      if (st_q.tick_cnt >= TICK_W'(TICK_N - 1)) begin
        st_d.tick_cnt = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.tick_cnt = st_q.tick_cnt + 1'b1;
      end
    end else begin
      st_d.scan_cnt = st_q.scan_cnt + 1'b1;
    end

    // elements evaluate once per scan
    if (st_q.scan) begin
      // latch: clear wins over set
      if (latch_i.clr) begin
        st_d.latch = 1'b0;
      end else if (latch_i.set) begin
        st_d.latch = 1'b1;
      end else begin
        st_d.latch = st_q.latch;
      end

      // toggle relay
      st_d.tog_prev = tog_i.set;
      if (tog_i.clr) begin
        st_d.tog = 1'b0;
      end else if (tog_rise) begin
        st_d.tog = ~st_q.tog;
      end

      // first scan after reset only learns the time
      st_d.seen = 1'b1;
      st_d.prev = now_i;
    end

    // weekly switch, later cams applied last so they win
    if (week_act) begin
      for (int c = 0; c < NUM_CAMS; c++) begin
        if (on_hit[c]) begin
          st_d.week = 1'b1;
        end
        if (off_hit[c]) begin
          st_d.week = 1'b0;
        end
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  // reset stands for power return; retained elements keep state
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= '0;
      st_q.latch <= latch_i.ret ? st_q.latch : OUT_RST;
      st_q.tog <= tog_i.ret ? st_q.tog : OUT_RST;
      st_q.tog_prev <= tog_i.ret ? st_q.tog_prev : OUT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************
  // pulse elements
  // ************************************************
  // level gated pulse
  rpw_pulse #(
    .MODE(RPW_PM_LEVEL)
  ) u_wipe (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .scan_i(st_q.scan),
    .tick_i(st_q.tick),
    .pin_i(wipe_i),
    .q_o(wipe_o)
  );

  // edge started, retriggerable pulse
  rpw_pulse #(
    .MODE(RPW_PM_EDGE)
  ) u_edge (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .scan_i(st_q.scan),
    .tick_i(st_q.tick),
    .pin_i(edge_i),
    .q_o(edge_o)
  );

  // ************************************************
  // outputs
  // ************************************************
  // all straight from state flops
  assign set_clear_latch_o = st_q.latch;
  assign toggle_o = st_q.tog;
  assign week_o = st_q.week;
  assign scan_o = st_q.scan;

  // ************************************************
  // checks
  // ************************************************
  // set alone raises the latch
  AST_LATCH_SET: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && latch_i.set && !latch_i.clr |=> set_clear_latch_o)
    else $error("latch not set");

  // clear beats set
  AST_LATCH_CLR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && latch_i.clr |=> !set_clear_latch_o)
    else $error("latch not cleared");

  // idle inputs hold the latch
  AST_LATCH_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && !latch_i.set && !latch_i.clr |=> $stable(set_clear_latch_o))
    else $error("latch changed with idle inputs");

  // retained latch survives reset
  AST_LATCH_RET: assert property (@(posedge clk_sys_i)
    srst_i && latch_i.ret |=> set_clear_latch_o == $past(set_clear_latch_o))
    else $error("retained latch lost");

  // rising trigger flips toggle
  AST_TOG_FLIP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && tog_rise && !tog_i.clr |=> toggle_o != $past(toggle_o))
    else $error("toggle did not flip");

  // no edge, no change
  AST_TOG_STEADY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && !tog_rise && !tog_i.clr |=> $stable(toggle_o))
    else $error("toggle changed without rising edge");

  // reset input clears toggle
  AST_TOG_CLR: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && tog_i.clr |=> !toggle_o)
    else $error("toggle not cleared");

  // unretained toggle powers up low
  AST_TOG_PWR: assert property (@(posedge clk_sys_i)
    srst_i && !tog_i.ret |=> !toggle_o)
    else $error("toggle not zero after power return");

  // highest cam with a hit decides
  AST_WEEK_PRIO: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    week_act && (on_hit[2] || off_hit[2]) |=> week_o == !$past(off_hit[2]))
    else $error("cam 3 did not win");

  // no hits, weekly output holds
  AST_WEEK_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    on_hit == '0 && off_hit == '0 |=> $stable(week_o))
    else $error("weekly output moved with no cam hit");

  // no scan in the four cycles after a scan
  AST_SCAN_GAP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan |=> !st_q.scan [*4])
    else $error("scan enable too frequent");

  // ************************************************
  // checks on power return, priority, scan timing, pulses and weekly switch
  // ************************************************
  // non-retained latch powers up low
  AST_LATCH_PWR: assert property (@(posedge clk_sys_i)
    srst_i && !latch_i.ret |=> !set_clear_latch_o)
    else $error("latch not zero after power return");

  // retained toggle survives reset
  AST_TOG_RET: assert property (@(posedge clk_sys_i)
    srst_i && tog_i.ret |=> toggle_o == $past(toggle_o))
    else $error("retained toggle lost");

  // reset leaves the unretained outputs low
  AST_OUT_RST: assert property (@(posedge clk_sys_i)
    srst_i |=> !week_o && !scan_o && !wipe_o && !edge_o)
    else $error("output high after reset");

  // both latch inputs high still clears
  AST_LATCH_BOTH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && latch_i.set && latch_i.clr |=> !set_clear_latch_o)
    else $error("set beat clear");

  // toggle reset beats a rising trigger
  AST_TOG_CLR_EDGE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && tog_i.clr && tog_rise |=> !toggle_o)
    else $error("toggle flipped while reset high");

  // latch moves only on a scan
  AST_LATCH_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !st_q.scan |=> $stable(set_clear_latch_o))
    else $error("latch moved between scans");

  // toggle moves only on a scan
  AST_TOG_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !st_q.scan |=> $stable(toggle_o))
    else $error("toggle moved between scans");

  // level pulse moves only on a scan
  AST_WIPE_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !st_q.scan |=> $stable(wipe_o))
    else $error("level pulse moved between scans");

  // edge pulse moves only on a scan
  AST_EDGE_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !st_q.scan |=> $stable(edge_o))
    else $error("edge pulse moved between scans");

  // timebase ticks only land on scans
  AST_TICK_SCAN: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.tick |-> st_q.scan)
    else $error("tick outside a scan");

  // no tick in the four cycles after a tick
  AST_TICK_GAP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.tick |=> !st_q.tick [*4])
    else $error("tick enable too frequent");

  // trigger low at a scan ends the level pulse
  AST_WIPE_LOW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && !wipe_i.trig |=> !wipe_o)
    else $error("level pulse high with trigger low");

  // held trigger and no tick keep the level pulse up
  AST_WIPE_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && wipe_o && wipe_i.trig && !st_q.tick |=> wipe_o)
    else $error("level pulse dropped early");

  // edge pulse ignores trigger level until time runs out
  AST_EDGE_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && edge_o && !st_q.tick |=> edge_o)
    else $error("edge pulse dropped early");

  // on hit with no off hit sets the weekly output
  AST_WEEK_ON: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    week_act && on_hit != '0 && off_hit == '0 |=> week_o)
    else $error("weekly output not set");

  // off hit with no on hit clears the weekly output
  AST_WEEK_OFF: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    week_act && off_hit != '0 && on_hit == '0 |=> !week_o)
    else $error("weekly output not cleared");

  // with cam 3 silent, cam 2 decides over cam 1
  AST_WEEK_CAM2: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    week_act && !on_hit[2] && !off_hit[2] && (on_hit[1] || off_hit[1])
    |=> week_o == !$past(off_hit[1]))
    else $error("cam 2 did not win");

  // weekly output only moves when a minute is newly reached
  AST_WEEK_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !week_act |=> $stable(week_o))
    else $error("weekly output moved without a new minute");

  // first scan after reset only learns the time
  AST_WEEK_FIRST: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scan && !st_q.seen |=> $stable(week_o))
    else $error("weekly output moved on first scan");
endmodule

// ### sim/rpw_cal.sv
`timescale 1ns/1ns
// ************************************************
// calendar source feeding the weekly switch
// ************************************************
module rpw_cal (
  // clock
  input wire logic clk_sys_i,
  // load a time or advance one minute
  input wire logic load_i,
  input wire logic adv_i,
  input wire rpw_pkg::rpw_clock_t set_i,
  // current weekday and minute
  output rpw_pkg::rpw_clock_t now_o
);
  import rpw_pkg::*;
  // minute steps wrap at end of day into the next weekday
  always @(posedge clk_sys_i) begin
    if (load_i) begin
      now_o <= set_i;
    end else if (adv_i) begin
      if (now_o.min == MIN_LAST) begin
        now_o.min <= 11'h000;
        now_o.day <= (now_o.day == DAY_SUN) ? 3'h0 : now_o.day + 3'h1;
      end else begin
        now_o.min <= now_o.min + 11'h001;
      end
    end
  end
endmodule

// ### sim/relay_pulse_weekly_timer_functions_bench.sv
`timescale 1ns/1ns
module relay_pulse_weekly_timer_functions_bench;
  import rpw_pkg::*;
  // ************************************************
  // settings and signals
  // ************************************************
  localparam int TN = 2; // short tick for simulation
  localparam int D = 3; // pulse duration in ticks
  localparam int CEIL = 40000; // cycle ceiling
  logic clk_sys_i = 1'b0;
  logic srst_i;
  rpw_ctl_t latch_i;
  rpw_ctl_t tog_i;
  rpw_pulse_in_t wipe_i;
  rpw_pulse_in_t edge_i;
  rpw_clock_t now_i;
  rpw_clock_t cal_set;
  rpw_cam_t [NUM_CAMS-1:0] cam_i;
  logic cal_load;
  logic cal_adv;
  logic set_clear_latch_o;
  logic toggle_o;
  logic wipe_o;
  logic edge_o;
  logic week_o;
  logic scan_o;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  // ************************************************
  // instances
  // ************************************************
  rpw_top #(.TICK_N(TN)) rpw_top_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .latch_i(latch_i), .tog_i(tog_i),
    .wipe_i(wipe_i), .edge_i(edge_i), .now_i(now_i), .cam_i(cam_i),
    .set_clear_latch_o(set_clear_latch_o), .toggle_o(toggle_o), .wipe_o(wipe_o),
    .edge_o(edge_o), .week_o(week_o), .scan_o(scan_o)
  );
  rpw_cal rpw_cal_inst (
    .clk_sys_i(clk_sys_i), .load_i(cal_load), .adv_i(cal_adv), .set_i(cal_set),
    .now_o(now_i)
  );
  // clock and cycle ceiling
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_fail++;
      close_out();
    end
  end
  // ************************************************
  // helpers
  // ************************************************
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // let one scan take the inputs, then wait for the outputs
  task automatic step();
    for (int i = 0; i < 300 && scan_o !== 1'b1; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic rst(input int n);
    srst_i = 1'b1;
    repeat (n) @(negedge clk_sys_i);
    srst_i = 1'b0;
  endtask
  // scans until the chosen pulse falls, judged against the duration
  task automatic fall_len(input logic sel);
    int k;
    for (k = 1; k < 20; k++) begin
      step();
      if ((sel ? edge_o : wipe_o) === 1'b0) break;
    end
    comparisons++;
    if (k < (D - 1) * TN || k > D * TN) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, k, D * TN);
    end
  endtask
  task automatic cams_unused();
    for (int c = 0; c < NUM_CAMS; c++) cam_i[c] = '{7'h7F, MIN_UNUSED, MIN_UNUSED};
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_latch();
    latch_i = '{1'b1, 1'b0, 1'b0};
    step();
    chk(set_clear_latch_o, 1'b1);
    latch_i.set = 1'b0;
    step();
    chk(set_clear_latch_o, 1'b1);
    latch_i = '{1'b1, 1'b1, 1'b0};
    step();
    chk(set_clear_latch_o, 1'b0);
    latch_i = '{1'b1, 1'b0, 1'b1};
    step();
    latch_i.set = 1'b0;
    rst(2);
    step();
    chk(set_clear_latch_o, 1'b1);
    latch_i.ret = 1'b0;
    rst(2);
    chk(set_clear_latch_o, 1'b0);
  endtask
  // rise then fall, each seen by its own scan
  task automatic tog_pulse(input logic exp);
    tog_i.set = 1'b1;
    step();
    chk(toggle_o, exp);
    tog_i.set = 1'b0;
    step();
    chk(toggle_o, exp);
  endtask
  task automatic t_tog();
    tog_pulse(1'b1);
    tog_pulse(1'b0);
    tog_pulse(1'b1);
    tog_i.clr = 1'b1;
    step();
    chk(toggle_o, 1'b0);
    tog_i.clr = 1'b0;
    tog_pulse(1'b1);
    rst(2);
    chk(toggle_o, 1'b0);
    tog_i.ret = 1'b1;
    tog_pulse(1'b1);
    rst(2);
    step();
    chk(toggle_o, 1'b1);
  endtask
  task automatic t_wipe();
    wipe_i = '{1'b1, DUR_W'(D)};
    step();
    chk(wipe_o, 1'b1);
    fall_len(1'b0);
    wipe_i.trig = 1'b0;
    step();
    wipe_i.trig = 1'b1;
    step();
    chk(wipe_o, 1'b1);
    wipe_i.trig = 1'b0;
    step();
    chk(wipe_o, 1'b0);
  endtask
  task automatic t_edge();
    edge_i = '{1'b1, DUR_W'(D)};
    step();
    chk(edge_o, 1'b1);
    edge_i.trig = 1'b0;
    repeat (3) step();
    chk(edge_o, 1'b1);
    edge_i.trig = 1'b1;
    step();
    chk(edge_o, 1'b1);
    fall_len(1'b1);
  endtask
  // load or advance the calendar, then judge the weekly output
  task automatic wk(input logic adv, input rpw_clock_t t, input logic exp);
    cal_adv = adv;
    cal_load = ~adv;
    cal_set = t;
    @(negedge clk_sys_i);
    cal_adv = 1'b0;
    cal_load = 1'b0;
    step();
    chk(week_o, exp);
  endtask
  task automatic t_week();
    cam_i[0] = '{7'h61, 11'h00A, 11'h01E};
    cam_i[1] = '{7'h7F, 11'h01E, MIN_LAST};
    cam_i[2] = '{7'h7F, MIN_LAST, 11'h014};
    wk(1'b0, '{3'h0, 11'h009}, 1'b0);
    wk(1'b0, '{3'h0, 11'h00A}, 1'b1);
    wk(1'b0, '{3'h0, 11'h00B}, 1'b1);
    wk(1'b0, '{3'h0, 11'h014}, 1'b0);
    wk(1'b0, '{3'h0, 11'h01E}, 1'b1);
    wk(1'b0, '{3'h0, MIN_LAST}, 1'b1);
    wk(1'b1, '{3'h0, 11'h000}, 1'b1);
    wk(1'b0, '{3'h1, 11'h014}, 1'b0);
    wk(1'b0, '{3'h1, 11'h00A}, 1'b0);
    wk(1'b0, '{3'h6, 11'h00A}, 1'b1);
    cams_unused();
    wk(1'b0, '{3'h6, 11'h014}, 1'b1);
    wk(1'b0, '{3'h6, MIN_UNUSED}, 1'b1);
  endtask
  // count cycles from one scan to the next, then see the flag drop
  task automatic t_scan();
    int n;
    step();
    n = 2;
    while (scan_o !== 1'b1 && n < 2 * SCAN_CYC) begin
      @(negedge clk_sys_i);
      n++;
    end
    comparisons++;
    if (n != SCAN_CYC) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, n, SCAN_CYC);
    end
    @(negedge clk_sys_i);
    chk(scan_o, 1'b0);
  endtask
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    srst_i = 1'b1;
    latch_i = '0;
    tog_i = '0;
    wipe_i = '0;
    edge_i = '0;
    cams_unused();
    cal_set = '0;
    cal_load = 1'b1;
    cal_adv = 1'b0;
    @(negedge clk_sys_i);
    rst(12);
    cal_load = 1'b0;
    t_latch();
    t_tog();
    t_wipe();
    t_edge();
    t_week();
    t_scan();
    close_out();
  end
endmodule
